// >>> apci_int_status.v
/*
 * sticky interrupt status for alarm indication, pattern sync and loop code events,
 * with an axi4-lite slave for the registers and one level interrupt output.
 * assumes live status inputs come from other clock domains or pins.
 *
 * register map, one 32-bit word each, data in bits 7:0, upper bits read zero:
 *   0x0 sticky flags: read the flags, write one to clear a flag
 *   0x4 edge select: bit 6 alarm pair, bit 5 pattern sync, bit 0 loop codes
 *   0x8 live status: read only, the synchronised live inputs
 *   0xc interrupt enable: same layout as the flags, all enabled after reset
 *
 * flag layout:
 *   bit 7 system side alarm indication
 *   bit 6 line side alarm indication
 *   bit 5 pattern synchronisation
 *   bits 4 to 2 reserved, always zero
 *   bit 1 loop code activate
 *   bit 0 loop code deactivate
 *
 * edge selection:
 *   select bit 0: a flag sets on a low to high change of its live bit
 *   select bit 1: a flag sets on any change of its live bit
 *   the alarm pair shares one select bit, so do the two loop codes
 *
 * event timing:
 *   live inputs pass two flip-flops before any logic reads them
 *   a third stage holds the previous value for edge finding
 *   a live change shows in the flag two edges after it is sampled
 *   irq is registered from the next flag value, so it rises with the flag
 *   a live input already high at reset release gives one rising event
 *
 * clear and set:
 *   a clear takes effect at the edge where the write is applied
 *   an event in that same cycle wins, so no event is ever lost
 *   software that clears a flag should read it back if it needs certainty
 *
 * bus behaviour:
 *   write address and write data are taken in either order
 *   the write is applied at the edge where the second half is taken
 *   the response follows one cycle later and stands until bready
 *   address and data readies stay low while a response is pending
 *   reads answer one cycle after the address is taken
 *   read data and response stand until rready
 *   unmapped addresses answer slverr; writes to them change nothing
 *   a write with byte lane 0 disabled changes nothing
 *
 * hazards and limits:
 *   the live inputs must stay stable for at least one clock to be seen
 *   pulses shorter than a clock may be missed by the synchroniser
 *   two live changes within one clock of each other may merge
 *   the enable register only gates irq, never the flags themselves
 *   changing an edge select bit does not create an event by itself
 *
 * reset:
 *   synchronous, active low, held for at least one edge
 *   flags, select and live copies clear; enable returns to 0xe3, every flag enabled
 *   all bus valid and ready outputs are low during reset
 *   readies rise at the first edge after release
 */
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "apci_map.vh"
module apci_int_status (
    input wire aclk,
    input wire aresetn,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire system_alarm_indication_live,
    input wire line_alarm_indication_live,
    input wire pattern_sync_live,
    input wire loop_code_activate_live,
    input wire loop_code_deactivate_live,
    output reg irq
);

    reg [7:0] alarm_pattern_code_int_status;
    reg [7:0] interrupt_edge_select_reg;
    reg [7:0] int_enable;
    reg [7:0] live_meta;
    reg [7:0] live_status_reg_one;
    reg [7:0] live_prev;
    reg [3:0] wr_addr;
    reg wr_addr_held;
    reg [31:0] wr_data;
    reg [3:0] wr_strb;
    reg wr_data_held;
    wire [7:0] live_raw;
    wire [7:0] rise;
    wire [7:0] change;
    wire [7:0] any_sel;
    wire [7:0] set_ev;
    wire do_write;
    wire [3:0] w_addr;
    wire [31:0] w_data;
    wire w_lane0;
    wire [7:0] clr;
    reg [7:0] next_status;

    // decode one register read
    // reserved flag bits are masked here as well as in the flag logic
    function [31:0] read_word;
        input [3:0] addr;
        input [7:0] st;
        input [7:0] sel;
        input [7:0] live;
        input [7:0] en;
        begin
            case (addr)
                `APCI_OFF_STATUS: read_word = {24'h000000, st & `APCI_FLAG_MASK};
                `APCI_OFF_EDGE_SEL: read_word = {24'h000000, sel};
                `APCI_OFF_LIVE: read_word = {24'h000000, live};
                `APCI_OFF_ENABLE: read_word = {24'h000000, en};
                default: read_word = 32'h00000000;
            endcase
        end
    endfunction

    // true when the address is mapped
    function addr_ok;
        input [3:0] addr;
        begin
            addr_ok = (addr == `APCI_OFF_STATUS) || (addr == `APCI_OFF_EDGE_SEL) ||
                      (addr == `APCI_OFF_LIVE) || (addr == `APCI_OFF_ENABLE);
        end
    endfunction

    // live bits gathered in register layout; reserved bits stay zero
    assign live_raw = {system_alarm_indication_live, line_alarm_indication_live,
                       pattern_sync_live, 3'b000, loop_code_activate_live,
                       loop_code_deactivate_live};

    // two-stage synchroniser, then a previous-cycle copy for edge finding
    // only the second stage and later are read, never the first
    always @(posedge aclk) begin
        if (!aresetn) begin
            live_meta <= 8'h00;
            live_status_reg_one <= 8'h00;
            live_prev <= 8'h00;
        end else begin
            live_meta <= live_raw;
            live_status_reg_one <= live_meta;
            live_prev <= live_status_reg_one;
        end
    end

    // per-flag edge select: alarm pair shares one bit, loop codes share one bit
    assign any_sel[`APCI_BIT_SYS_AIS] = interrupt_edge_select_reg[`APCI_SEL_AIS];
    assign any_sel[`APCI_BIT_LINE_AIS] = interrupt_edge_select_reg[`APCI_SEL_AIS];
    assign any_sel[`APCI_BIT_PAT] = interrupt_edge_select_reg[`APCI_SEL_PAT];
    assign any_sel[4:2] = 3'b000;
    assign any_sel[`APCI_BIT_ACT] = interrupt_edge_select_reg[`APCI_SEL_IB];
    assign any_sel[`APCI_BIT_DEACT] = interrupt_edge_select_reg[`APCI_SEL_IB];

    // rising or any edge per flag
    assign rise = live_status_reg_one & ~live_prev;
    assign change = live_status_reg_one ^ live_prev;
    assign set_ev = ((any_sel & change) | (~any_sel & rise)) & `APCI_FLAG_MASK;

    // write takes effect once address and data are both held or arriving
    // no write is applied while a response still waits for bready
    assign w_addr = wr_addr_held ? wr_addr : s_axi_awaddr;
    assign w_data = wr_data_held ? wr_data : s_axi_wdata;
    assign w_lane0 = wr_data_held ? wr_strb[0] : s_axi_wstrb[0];
    assign do_write = (wr_addr_held | (s_axi_awvalid & s_axi_awready)) &
                      (wr_data_held | (s_axi_wvalid & s_axi_wready)) & ~s_axi_bvalid;
    assign clr = (do_write && w_lane0 && w_addr == `APCI_OFF_STATUS) ?
                 (w_data[7:0] & `APCI_FLAG_MASK) : 8'h00;

    // sticky flags: set wins over clear
    always @* begin
        next_status = ((alarm_pattern_code_int_status & ~clr) | set_ev) & `APCI_FLAG_MASK;
    end

    // status, control registers and interrupt output
    // irq follows the next flag value so it never lags the flags
    always @(posedge aclk) begin
        if (!aresetn) begin
            alarm_pattern_code_int_status <= `APCI_RST_STATUS;
            interrupt_edge_select_reg <= `APCI_RST_EDGE_SEL;
            int_enable <= `APCI_RST_ENABLE;
            irq <= 1'b0;
        end else begin
            alarm_pattern_code_int_status <= next_status;
            if (do_write && w_lane0 && w_addr == `APCI_OFF_EDGE_SEL) begin
                interrupt_edge_select_reg <= w_data[7:0] & `APCI_SEL_MASK;
            end
            if (do_write && w_lane0 && w_addr == `APCI_OFF_ENABLE) begin
                int_enable <= w_data[7:0] & `APCI_FLAG_MASK;
            end
            irq <= |(next_status & int_enable);
        end
    end

    // write channels: address and data accepted in either order
    // later assignments below override the default ready update
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `APCI_RESP_OKAY;
            wr_addr_held <= 1'b0;
            wr_data_held <= 1'b0;
            wr_addr <= 4'h0;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
        end else begin
            s_axi_awready <= ~wr_addr_held & ~(s_axi_awvalid & s_axi_awready) & ~do_write;
            s_axi_wready <= ~wr_data_held & ~(s_axi_wvalid & s_axi_wready) & ~do_write;
            if (do_write) begin
                wr_addr_held <= 1'b0;
                wr_data_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_ok(w_addr) ? `APCI_RESP_OKAY : `APCI_RESP_SLVERR;
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    wr_addr_held <= 1'b1;
                    wr_addr <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    wr_data_held <= 1'b1;
                    wr_data <= s_axi_wdata;
                    wr_strb <= s_axi_wstrb;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end else if (s_axi_bvalid) begin
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
            end
        end
    end

    // read channel: one read at a time, answer the cycle after the address
    // arready stays low while read data waits for rready
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `APCI_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= read_word(s_axi_araddr, alarm_pattern_code_int_status,
                                         interrupt_edge_select_reg, live_status_reg_one,
                                         int_enable);
                s_axi_rresp <= addr_ok(s_axi_araddr) ? `APCI_RESP_OKAY : `APCI_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

// >>> apci_int_status_chk.sv
/* checker: bus handshakes, read data and irq of the interrupt status block.
   bound to apci_int_status; sees only its ports. */
`timescale 1ns/10ps
module apci_int_status_chk (
    input wire aclk, input wire aresetn, input wire irq,
    input wire s_axi_awvalid, input wire s_axi_awready,
    input wire s_axi_wvalid, input wire s_axi_wready, input wire s_axi_bvalid,
    input wire s_axi_bready, input wire s_axi_arvalid, input wire s_axi_arready,
    input wire [31:0] s_axi_rdata, input wire s_axi_rvalid, input wire s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // either half of a write taken at this edge
    wire wr_beat = s_axi_awvalid && s_axi_awready || s_axi_wvalid && s_axi_wready;
    sequence s_wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
    sequence s_wr_recent; $past(wr_beat) || $past(wr_beat, 2); endsequence
    AST_RST_IDLE: assert property ($rose(aresetn) |-> !irq && !s_axi_rvalid)
        else $error("busy after reset");
    AST_IRQ_FALL: assert property ($fell(irq) |-> s_wr_recent)
        else $error("irq dropped without a write");
    AST_WR_RESP: assert property (s_wr_take |=> s_axi_bvalid && !s_axi_awready)
        else $error("no write response");
    AST_B_WAIT: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
        else $error("write side not reopened");
    AST_RD_RESP: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("no read response");
    AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read side not reopened");
    AST_RSV_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[4:2] == 3'h0)
        else $error("reserved bits set");
endmodule
bind apci_int_status apci_int_status_chk u_chk (.*);

// >>> apci_int_status_tb.sv
/* bench for the interrupt status block: axi4-lite tasks and register checks.
   assumes the hand-over map: 0x0 flags, 0x4 edge select, 0x8 live, 0xc enable. */
`timescale 1ns/10ps
module apci_int_status_tb;
    reg aclk = 0;
    reg aresetn = 0;
    reg [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    reg [31:0] s_axi_wdata = 32'h0;
    reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    reg s_axi_rready = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    reg [4:0] lv = 5'h0;
    wire system_alarm_indication_live = lv[4];
    wire line_alarm_indication_live = lv[3];
    wire pattern_sync_live = lv[2];
    wire loop_code_activate_live = lv[1];
    wire loop_code_deactivate_live = lv[0];
    reg [31:0] d;
    reg [1:0] r;
    integer n_fail = 0, checks = 0, i;
    apci_int_status DUT (.*);
    // bus clock
    initial forever #25 aclk = ~aclk;
    // compare and count
    task chk(input [31:0] s, input [31:0] e);
        begin
            checks = checks + 1;
            if (s !== e) begin
                n_fail = n_fail + 1;
                $display("mismatch %0t: got %h want %h", $time, s, e);
            end
        end
    endtask
    // one write; holds each channel until taken
    task wr(input [3:0] a, input [31:0] v);
        reg done;
        begin
            done = 0;
            s_axi_awaddr <= a;
            s_axi_wdata <= v;
            s_axi_awvalid <= 1;
            s_axi_wvalid <= 1;
            s_axi_bready <= 1;
            while (!done) begin
                @(posedge aclk);
                if (s_axi_awready) s_axi_awvalid <= 0;
                if (s_axi_wready) s_axi_wvalid <= 0;
                if (s_axi_bvalid) begin
                    r = s_axi_bresp;
                    done = 1;
                end
            end
        end
    endtask
    // one read, then compare the data
    task rc(input [3:0] a, input [31:0] e);
        reg done;
        begin
            done = 0;
            s_axi_araddr <= a;
            s_axi_arvalid <= 1;
            s_axi_rready <= 1;
            while (!done) begin
                @(posedge aclk);
                if (s_axi_arready) s_axi_arvalid <= 0;
                if (s_axi_rvalid) begin
                    d = s_axi_rdata;
                    r = s_axi_rresp;
                    done = 1;
                end
            end
            chk(d, e);
        end
    endtask
    // flag position of live input i
    function [31:0] fb(input integer i);
        fb = (i > 1) ? 32'h1 << (i + 3) : 32'h1 << i;
    endfunction
    task conclude;
        begin
            $display("checks %0d n_fail %0d", checks, n_fail);
            if (n_fail == 0 && checks > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    // main sequence
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rc(4'h0, 32'h0);
        rc(4'hc, 32'he3);
        chk(irq, 32'h0);
        for (i = 0; i < 5; i = i + 1) begin
            lv[i] <= 1;
            repeat (6) @(posedge aclk);
            rc(4'h0, fb(i));
            chk(irq, 32'h1);
            wr(4'h0, 32'h0);
            rc(4'h0, fb(i));
            wr(4'h0, fb(i));
            rc(4'h0, 32'h0);
            lv[i] <= 0;
            repeat (6) @(posedge aclk);
            rc(4'h0, 32'h0);
            chk(irq, 32'h0);
        end
        wr(4'h4, 32'hff);
        rc(4'h4, 32'h61);
        lv <= 5'h1f;
        repeat (6) @(posedge aclk);
        rc(4'h8, 32'he3);
        wr(4'h0, 32'hff);
        lv <= 5'h0;
        repeat (6) @(posedge aclk);
        rc(4'h0, 32'he3);
        wr(4'hc, 32'h0);
        @(posedge aclk);
        chk(irq, 32'h0);
        wr(4'hc, 32'he3);
        @(posedge aclk);
        chk(irq, 32'h1);
        wr(4'h0, 32'hff);
        rc(4'h0, 32'h0);
        rc(4'h2, 32'h0);
        chk(r, 32'h2);
        conclude;
    end
    // watchdog
    initial begin
        #400000;
        n_fail = n_fail + 1;
        conclude;
    end
endmodule

// >>> apci_map.vh
/*
 * register map and constants for the alarm, pattern and loop code interrupt block.
 * assumes a 32-bit axi4-lite bus with word aligned registers.
 */
`ifndef APCI_MAP_VH
`define APCI_MAP_VH
`define APCI_OFF_STATUS 4'h0
`define APCI_OFF_EDGE_SEL 4'h4
`define APCI_OFF_LIVE 4'h8
`define APCI_OFF_ENABLE 4'hc
`define APCI_BIT_SYS_AIS 7
`define APCI_BIT_LINE_AIS 6
`define APCI_BIT_PAT 5
`define APCI_BIT_ACT 1
`define APCI_BIT_DEACT 0
`define APCI_SEL_AIS 6
`define APCI_SEL_PAT 5
`define APCI_SEL_IB 0
`define APCI_FLAG_MASK 8'he3
`define APCI_SEL_MASK 8'h61
`define APCI_RST_STATUS 8'h00
`define APCI_RST_EDGE_SEL 8'h00
`define APCI_RST_ENABLE 8'he3
`define APCI_RESP_OKAY 2'b00
`define APCI_RESP_SLVERR 2'b10
`endif
